// >>> servo_config_command_decoder.v
// servo configuration command decoder with apb register port
// Notes on behaviour
// R1: command 186 selects serial interface; 0 is rs-232 (default), 1 is rs-485.
// R2: reply of an interface select goes out on the newly selected interface.
// R3: on rs-485-only variants the interface stays rs-485 whatever is asked.
// R4: command 130 sets encoder glitch filter; 0 gives 100 ns, 1 gives 300 ns.
// R5: filter each of three encoder lines separately; raw lines stay for general inputs.
// R6: command 244, no parameter, enters single loop mode on internal encoder.
// R7: single loop command while motion runs raises an error.
// R8: entering single loop copies internal position into target position.
// R9: single loop mode is selected from power-up.
// R10: all mode settings share one command; mode number picks the setting.
// R11: set-mode is command 86 with unsigned mode and signed data words.
// R12: mode 0 on fieldbus units: 0 disables, 1 enables limit switches.
// R13: mode 1 enables answering the group identifier too.
// R14: mode 2: 0 stepper or hybrid servo, 1 dc motor.
// R15: mode 3 selects analog feedback source, values 0 to 4.
// R16: mode 4 sets filter for analog inputs 4 to 7 and feedback.
// R17: mode 5 sets the drive voltage filter.
// R18: mode 6 sets velocity crossover frequency.
// R19: mode 7 n gives prescale 2^n pulse width capture; 0 returns encoder counts.
// R20: accepted commands answer with acknowledge only; unsupported modes give error.
`timescale 1ns/100ps
`default_nettype none
`include "cfg_decoder_consts.vh"
module servo_config_command_decoder
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rs485_only,
    input wire fieldbus_fitted,
    input wire motion_running,
    input wire [31:0] internal_position,
    input wire [2:0] enc_lines,
    input wire pulse_in6,
    input wire pulse_in7,
    output wire [2:0] enc_lines_filtered,
    output wire [2:0] io_lines_raw,
    output reg rs485_select_r,
    output reg reply_if_rs485_r,
    output reg single_loop_r,
    output reg limit_enable_r,
    output reg group_enable_r,
    output reg dc_motor_r,
    output reg [2:0] feedback_src_r,
    output reg [15:0] analog_filter_r,
    output reg [15:0] drive_filter_r,
    output reg [15:0] crossover_r,
    output reg pw_enable_r,
    output reg [15:0] pw_high6_r,
    output reg [15:0] pw_high7_r,
    output reg [31:0] target_r,
    output reg target_load_r
);
// ==========================================================================
// register file
reg [7:0] cmd_r;
reg [15:0] param_r;
reg [15:0] data_r;
reg ack_r;
reg err_r;
reg filt300_r;
reg [3:0] prescale_r;
reg strap_r;
reg strap_taken_r;
wire wr_en;
wire rd_en;
wire go;
wire addr_ok;

assign pready = 1'b1;
assign wr_en = psel & penable & pwrite;
assign rd_en = psel & penable & ~pwrite;
assign go = wr_en & (paddr == `OFF_GO);
assign addr_ok = (paddr == `OFF_CMD) | (paddr == `OFF_PARAM) | (paddr == `OFF_DATA) |
    (paddr == `OFF_GO) | (paddr == `OFF_STATUS) | (paddr == `OFF_CONFIG) |
    (paddr == `OFF_FILTERS) | (paddr == `OFF_POSITION) | (paddr == `OFF_TARGET) |
    (paddr == `OFF_STRAP);
// unmapped addresses answer with an error, reads return zero
assign pslverr = psel & penable & ~addr_ok;

function is_bool;
    input [15:0] v;
    begin
        is_bool = (v == `DATA_ZERO) | (v == `DATA_ONE);
    end
endfunction

always @*
begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
        case (paddr)
            `OFF_CMD: prdata = {24'h00_0000, cmd_r};
            `OFF_PARAM: prdata = {16'h0000, param_r};
            `OFF_DATA: prdata = {16'h0000, data_r};
            `OFF_STATUS: prdata = {29'h0000_0000, motion_running, err_r, ack_r};
            `OFF_CONFIG: prdata = {16'h0000, prescale_r, 1'b0, feedback_src_r,
                2'b00, dc_motor_r, group_enable_r, limit_enable_r, single_loop_r,
                filt300_r, rs485_select_r};
            `OFF_FILTERS: prdata = {drive_filter_r, analog_filter_r};
            `OFF_POSITION: prdata = {crossover_r, 16'h0000};
            `OFF_TARGET: prdata = target_r;
            `OFF_STRAP: prdata = {31'h0000_0000, strap_r};
            default: prdata = 32'h0000_0000;
        endcase
    end
end

// strap caught after reset release, never under reset
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        strap_r <= 1'b0;
        strap_taken_r <= 1'b0;
    end
    else if (!strap_taken_r)
    begin
        strap_r <= rs485_only;
        strap_taken_r <= 1'b1;
    end
end

// ==========================================================================
// command execution; a go write runs the staged command in one cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cmd_r <= 8'h00;
        param_r <= 16'h0000;
        data_r <= 16'h0000;
        ack_r <= 1'b0;
        err_r <= 1'b0;
        rs485_select_r <= 1'b0; // R1
        reply_if_rs485_r <= 1'b0;
        filt300_r <= 1'b0; // R4
        single_loop_r <= 1'b1; // R9
        limit_enable_r <= 1'b0;
        group_enable_r <= 1'b0;
        dc_motor_r <= 1'b0;
        feedback_src_r <= 3'b000;
        analog_filter_r <= 16'h0000;
        drive_filter_r <= 16'h0000;
        crossover_r <= 16'h0000;
        prescale_r <= 4'h0;
        pw_enable_r <= 1'b0;
        target_r <= 32'h0000_0000;
        target_load_r <= 1'b0;
    end
    else
    begin
        target_load_r <= 1'b0;
        if (strap_taken_r && strap_r)
        begin
            rs485_select_r <= 1'b1; // R3
            reply_if_rs485_r <= 1'b1; // R3
        end
        if (wr_en && paddr == `OFF_CMD)
            cmd_r <= pwdata[7:0];
        if (wr_en && paddr == `OFF_PARAM)
            param_r <= pwdata[15:0];
        if (wr_en && paddr == `OFF_DATA)
            data_r <= pwdata[15:0];
        // writing status clears ack and error bits by writing ones
        if (wr_en && paddr == `OFF_STATUS)
        begin
            if (pwdata[`ST_ACK])
                ack_r <= 1'b0;
            if (pwdata[`ST_ERR])
                err_r <= 1'b0;
        end
        if (go)
        begin
            ack_r <= 1'b0; // R20
            err_r <= 1'b0;
            case (cmd_r)
                `CMD_SERIAL_IF:
                begin
                    if (is_bool(param_r))
                    begin
                        // reply follows the new interface
                        rs485_select_r <= param_r[0] | strap_r; // R1 R3
                        reply_if_rs485_r <= param_r[0] | strap_r; // R2
                        ack_r <= 1'b1;
                    end
                    else
                        err_r <= 1'b1;
                end
                `CMD_ENC_FILTER:
                begin
                    if (is_bool(param_r))
                    begin
                        filt300_r <= param_r[0]; // R4
                        ack_r <= 1'b1;
                    end
                    else
                        err_r <= 1'b1;
                end
                `CMD_SINGLE_LOOP:
                begin
                    if (motion_running)
                        err_r <= 1'b1; // R7
                    else
                    begin
                        single_loop_r <= 1'b1; // R6
                        target_r <= internal_position; // R8
                        target_load_r <= 1'b1; // R8
                        ack_r <= 1'b1;
                    end
                end
                `CMD_SET_MODE:
                begin
                    ack_r <= 1'b1; // R10 R11
                    case (param_r)
                        `MODE_LIMIT:
                            if (fieldbus_fitted && is_bool(data_r))
                                limit_enable_r <= data_r[0]; // R12
                            else
                            begin
                                ack_r <= 1'b0;
                                err_r <= 1'b1;
                            end
                        `MODE_GROUP:
                            if (is_bool(data_r))
                                group_enable_r <= data_r[0]; // R13
                            else
                            begin
                                ack_r <= 1'b0;
                                err_r <= 1'b1;
                            end
                        `MODE_DC:
                            if (is_bool(data_r))
                                dc_motor_r <= data_r[0]; // R14
                            else
                            begin
                                ack_r <= 1'b0;
                                err_r <= 1'b1;
                            end
                        `MODE_AFB:
                            if (data_r <= `AFB_MAX)
                                feedback_src_r <= data_r[2:0]; // R15
                            else
                            begin
                                ack_r <= 1'b0;
                                err_r <= 1'b1;
                            end
                        `MODE_AIN_FILT: analog_filter_r <= data_r; // R16
                        `MODE_DRV_FILT: drive_filter_r <= data_r; // R17
                        `MODE_VEL_XOVER: crossover_r <= data_r; // R18
                        `MODE_PWIDTH:
                            if (data_r <= `PRESCALE_MAX)
                            begin
                                prescale_r <= data_r[3:0]; // R19
                                pw_enable_r <= (data_r != `DATA_ZERO); // R19
                            end
                            else
                            begin
                                ack_r <= 1'b0;
                                err_r <= 1'b1;
                            end
                        default:
                        begin
                            ack_r <= 1'b0;
                            err_r <= 1'b1; // R20
                        end
                    endcase
                end
                default:
                    err_r <= 1'b1; // R20
            endcase
        end
    end
end

// ==========================================================================
// encoder glitch filter, one counter per line
wire [31:0] flen_full;
wire [`FCNT_W-1:0] flen;
assign flen_full = filt300_r ? `FILT_LONG_CYC : `FILT_SHORT_CYC; // R4
assign flen = flen_full[`FCNT_W-1:0];
assign io_lines_raw = enc_lines; // R5
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : line
        reg [`FCNT_W-1:0] cnt_r;
        reg out_r;
        assign enc_lines_filtered[gi] = out_r;
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt_r <= {`FCNT_W{1'b0}};
                out_r <= 1'b0;
            end
            else if (enc_lines[gi] == out_r)
                cnt_r <= {`FCNT_W{1'b0}};
            else if (cnt_r + 1'b1 >= flen)
            begin
                out_r <= enc_lines[gi]; // R5
                cnt_r <= {`FCNT_W{1'b0}};
            end
            else
                cnt_r <= cnt_r + 1'b1;
        end
    end
endgenerate

// ==========================================================================
// pulse width capture with 2^n prescale; counter saturates
reg [15:0] psc_cnt_r;
reg [`PW_W-1:0] pw6_cnt_r;
reg [`PW_W-1:0] pw7_cnt_r;
reg in6_d_r;
reg in7_d_r;
wire tick;
wire [15:0] psc_mask;
assign psc_mask = (16'h0001 << prescale_r) - 16'h0001;
assign tick = ((psc_cnt_r & psc_mask) == psc_mask);

function [`PW_W-1:0] sat_inc;
    input [`PW_W-1:0] v;
    begin
        sat_inc = (v == `PW_MAX) ? v : v + 1'b1;
    end
endfunction

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        psc_cnt_r <= 16'h0000;
        pw6_cnt_r <= 16'h0000;
        pw7_cnt_r <= 16'h0000;
        in6_d_r <= 1'b0;
        in7_d_r <= 1'b0;
        pw_high6_r <= 16'h0000;
        pw_high7_r <= 16'h0000;
    end
    else if (pw_enable_r)
    begin
        psc_cnt_r <= psc_cnt_r + 16'h0001;
        in6_d_r <= pulse_in6;
        in7_d_r <= pulse_in7;
        if (pulse_in6 && !in6_d_r)
            pw6_cnt_r <= 16'h0000;
        else if (pulse_in6 && tick)
            pw6_cnt_r <= sat_inc(pw6_cnt_r);
        if (!pulse_in6 && in6_d_r)
            pw_high6_r <= pw6_cnt_r; // R19
        if (pulse_in7 && !in7_d_r)
            pw7_cnt_r <= 16'h0000;
        else if (pulse_in7 && tick)
            pw7_cnt_r <= sat_inc(pw7_cnt_r);
        if (!pulse_in7 && in7_d_r)
            pw_high7_r <= pw7_cnt_r; // R19
    end
    else
    begin
        psc_cnt_r <= 16'h0000;
        in6_d_r <= 1'b0;
        in7_d_r <= 1'b0;
    end
end
endmodule
`default_nettype wire

// >>> cfg_decoder_consts.vh
// constants for the servo configuration command decoder
`ifndef CFG_DECODER_CONSTS_VH
`define CFG_DECODER_CONSTS_VH
// register byte offsets (apb)
`define ADDR_W 8
`define OFF_CMD 8'h00
`define OFF_PARAM 8'h04
`define OFF_DATA 8'h08
`define OFF_GO 8'h0C
`define OFF_STATUS 8'h10
`define OFF_CONFIG 8'h14
`define OFF_FILTERS 8'h18
`define OFF_POSITION 8'h1C
`define OFF_TARGET 8'h20
`define OFF_STRAP 8'h24
// command numbers
`define CMD_SERIAL_IF 8'hBA
`define CMD_ENC_FILTER 8'h82
`define CMD_SINGLE_LOOP 8'hF4
`define CMD_SET_MODE 8'h56
// set-mode numbers
`define MODE_LIMIT 16'h0000
`define MODE_GROUP 16'h0001
`define MODE_DC 16'h0002
`define MODE_AFB 16'h0003
`define MODE_AIN_FILT 16'h0004
`define MODE_DRV_FILT 16'h0005
`define MODE_VEL_XOVER 16'h0006
`define MODE_PWIDTH 16'h0007
// data values
`define DATA_ZERO 16'h0000
`define DATA_ONE 16'h0001
`define AFB_MAX 16'h0004
`define PRESCALE_MAX 16'h000F
// status bit positions
`define ST_ACK 0
`define ST_ERR 1
`define ST_BUSY 2
// config bit positions
`define CF_RS485 0
`define CF_FILT300 1
`define CF_SINGLE 2
`define CF_LIMIT 3
`define CF_GROUP 4
`define CF_DC 5
`define CF_AFB_LO 8
`define CF_PSC_LO 12
// encoder filter lengths
`define FILT_SHORT_NS 100
`define FILT_LONG_NS 300
`define CLK_NS 40
`define FILT_SHORT_CYC ((`FILT_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define FILT_LONG_CYC ((`FILT_LONG_NS + `CLK_NS - 1) / `CLK_NS)
`define FCNT_W 4
`define PW_W 16
`define PW_MAX 16'hFFFF
`endif

// >>> servo_cfg_properties.sv
// concurrent checks on the configuration decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "cfg_decoder_consts.vh"
module servo_cfg_checker
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire rs485_only,
    input wire motion_running,
    input wire [31:0] internal_position,
    input wire [2:0] enc_lines,
    input wire [2:0] io_lines_raw,
    input wire rs485_select_r,
    input wire reply_if_rs485_r,
    input wire single_loop_r,
    input wire group_enable_r,
    input wire dc_motor_r,
    input wire pw_enable_r,
    input wire [31:0] target_r,
    input wire target_load_r
);
    // ==========================================
    // shadow of the staged command words
    logic [7:0] cmd_r;
    logic [15:0] par_r;
    logic [15:0] dat_r;
    wire wr = psel && penable && pwrite;
    wire go = wr && paddr == `OFF_GO;
    // only boolean data, so the expected level is simply data bit 0
    wire set_md = go && cmd_r == `CMD_SET_MODE && dat_r <= `DATA_ONE;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r <= 8'h00;
            par_r <= 16'h0000;
            dat_r <= 16'h0000;
        end
        else if (wr)
        begin
            if (paddr == `OFF_CMD) cmd_r <= pwdata[7:0];
            if (paddr == `OFF_PARAM) par_r <= pwdata[15:0];
            if (paddr == `OFF_DATA) dat_r <= pwdata[15:0];
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_single; single_loop_r; endproperty
    a_single: assert property (p_single) else $error("single loop mode dropped");
    // the strap is caught one edge after release, so skip two edges
    property p_strap;
        rs485_only && $past(rs485_only) && $past(presetn, 2) |-> rs485_select_r;
    endproperty
    a_strap: assert property (p_strap) else $error("strap did not force rs485");
    property p_reply; $past(go) && !rs485_only |-> reply_if_rs485_r == rs485_select_r; endproperty
    a_reply: assert property (p_reply) else $error("reply interface differs");
    property p_target; target_load_r |-> target_r == $past(internal_position); endproperty
    a_target: assert property (p_target) else $error("target not copied");
    property p_busy; $past(motion_running) |-> !target_load_r; endproperty
    a_busy: assert property (p_busy) else $error("single loop entered in motion");
    property p_dc; set_md && par_r == `MODE_DC |=> dc_motor_r == dat_r[0]; endproperty
    a_dc: assert property (p_dc) else $error("dc motor select wrong");
    property p_group; set_md && par_r == `MODE_GROUP |=> group_enable_r == dat_r[0]; endproperty
    a_group: assert property (p_group) else $error("group enable wrong");
    property p_pw_off;
        set_md && par_r == `MODE_PWIDTH && dat_r == `DATA_ZERO |=> !pw_enable_r;
    endproperty
    a_pw_off: assert property (p_pw_off) else $error("pulse capture still on");
    property p_raw; io_lines_raw == enc_lines; endproperty
    a_raw: assert property (p_raw) else $error("raw lines filtered");
    property p_slverr; psel && penable && paddr > `OFF_STRAP |-> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access accepted");
    c_load: cover property (target_load_r);
    c_dc: cover property (set_md && par_r == `MODE_DC);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind servo_config_command_decoder servo_cfg_checker servo_cfg_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .rs485_only(rs485_only),
    .motion_running(motion_running), .internal_position(internal_position),
    .enc_lines(enc_lines), .io_lines_raw(io_lines_raw), .rs485_select_r(rs485_select_r),
    .reply_if_rs485_r(reply_if_rs485_r), .single_loop_r(single_loop_r),
    .group_enable_r(group_enable_r), .dc_motor_r(dc_motor_r), .pw_enable_r(pw_enable_r),
    .target_r(target_r), .target_load_r(target_load_r)
);
`default_nettype wire

// >>> servo_cfg_host.sv
// host model issuing apb transfers to the decoder
`timescale 1ns/100ps
`default_nettype none
module servo_cfg_host
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ==========================================
    // one transfer; command words go out whole, one per register
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        begin
            // an edge passes first so psel is never assigned twice in one step
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            pwdata <= ~d;
        end
    endtask
endmodule
`default_nettype wire

// >>> servo_config_command_decoder_tb.sv
// testbench for the servo configuration command decoder
`timescale 1ns/100ps
`default_nettype none
`include "cfg_decoder_consts.vh"
module servo_config_command_decoder_tb;
    logic pclk = 1'b0, presetn = 1'b0, rs485_only = 1'b0, fieldbus_fitted = 1'b1;
    logic motion_running = 1'b0, pulse_in6 = 1'b0, pulse_in7 = 1'b0;
    logic [2:0] enc_lines = 3'h0;
    logic [31:0] internal_position = 32'h0000_0000;
    wire psel, penable, pwrite, pready, pslverr, rs485_select_r, reply_if_rs485_r;
    wire single_loop_r, limit_enable_r, group_enable_r, dc_motor_r, pw_enable_r, target_load_r;
    wire [7:0] paddr;
    wire [2:0] feedback_src_r, enc_lines_filtered, io_lines_raw;
    wire [15:0] analog_filter_r, drive_filter_r, crossover_r, pw_high6_r, pw_high7_r;
    wire [31:0] pwdata, prdata, target_r;
    int num_errors = 0;
    int n_compared = 0;
    logic [31:0] q;
    logic e;
    logic [15:0] dv [8] = '{16'h0001, 16'h0001, 16'h0001, 16'h0003,
                            16'h0123, 16'h0456, 16'h0789, 16'h0004};
    // ==========================================
    // instances and clock
    servo_config_command_decoder servo_config_command_decoder_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rs485_only(rs485_only), .fieldbus_fitted(fieldbus_fitted),
        .motion_running(motion_running), .internal_position(internal_position),
        .enc_lines(enc_lines), .pulse_in6(pulse_in6), .pulse_in7(pulse_in7),
        .enc_lines_filtered(enc_lines_filtered), .io_lines_raw(io_lines_raw),
        .rs485_select_r(rs485_select_r), .reply_if_rs485_r(reply_if_rs485_r),
        .single_loop_r(single_loop_r), .limit_enable_r(limit_enable_r),
        .group_enable_r(group_enable_r), .dc_motor_r(dc_motor_r),
        .feedback_src_r(feedback_src_r), .analog_filter_r(analog_filter_r),
        .drive_filter_r(drive_filter_r), .crossover_r(crossover_r), .pw_enable_r(pw_enable_r),
        .pw_high6_r(pw_high6_r), .pw_high7_r(pw_high7_r), .target_r(target_r),
        .target_load_r(target_load_r)
    );
    servo_cfg_host servo_cfg_host_inst (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_compared++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic end_of_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task automatic reset_dut;
        begin
            presetn <= 1'b0;
            repeat (20) @(posedge pclk);
            presetn <= 1'b1;
            repeat (2) @(posedge pclk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        servo_cfg_host_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        servo_cfg_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask
    // st is the expected {err, ack}; 2'b11 leaves the status unjudged
    task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d,
                       input logic [1:0] st);
        begin
            wr(`OFF_CMD, {24'h00_0000, c});
            wr(`OFF_PARAM, {16'h0000, p});
            wr(`OFF_DATA, {16'h0000, d});
            wr(`OFF_GO, 32'h0000_0001);
            rd(`OFF_STATUS);
            if (st != 2'b11)
                check(q[1:0], st);
        end
    endtask
    function automatic logic [15:0] out_of(input int m);
        case (m)
            0: out_of = {15'h0000, limit_enable_r};
            1: out_of = {15'h0000, group_enable_r};
            2: out_of = {15'h0000, dc_motor_r};
            3: out_of = {13'h0000, feedback_src_r};
            4: out_of = analog_filter_r;
            5: out_of = drive_filter_r;
            6: out_of = crossover_r;
            default: out_of = {15'h0000, pw_enable_r};
        endcase
    endfunction
    // ==========================================
    // scenarios
    task automatic t_serial;
        begin
            rd(`OFF_CONFIG);
            check(q, 32'h0000_0004);
            cmd(`CMD_SERIAL_IF, `DATA_ONE, `DATA_ZERO, 2'b01);
            check({reply_if_rs485_r, rs485_select_r}, 2'b11);
            cmd(`CMD_SERIAL_IF, `DATA_ZERO, `DATA_ZERO, 2'b01);
            check({reply_if_rs485_r, rs485_select_r}, 2'b00);
            cmd(`CMD_SERIAL_IF, 16'h0002, `DATA_ZERO, 2'b10);
            rs485_only <= 1'b1;
            reset_dut;
            cmd(`CMD_SERIAL_IF, `DATA_ZERO, `DATA_ZERO, 2'b11);
            check(rs485_select_r, 1'b1);
            rs485_only <= 1'b0;
            reset_dut;
            $display("serial interface test done");
        end
    endtask
    task automatic t_filter;
        begin
            cmd(`CMD_ENC_FILTER, `DATA_ONE, `DATA_ZERO, 2'b01);
            rd(`OFF_CONFIG);
            check(q[`CF_FILT300], 1'b1);
            enc_lines <= 3'b001;
            repeat (5) @(posedge pclk);
            check({io_lines_raw, enc_lines_filtered}, 6'b001_000);
            repeat (8) @(posedge pclk);
            check(enc_lines_filtered, 3'b001);
            cmd(`CMD_ENC_FILTER, `DATA_ZERO, `DATA_ZERO, 2'b01);
            // a two-cycle glitch on one line is shorter than the short filter
            enc_lines <= 3'b011;
            repeat (2) @(posedge pclk);
            enc_lines <= 3'b101;
            repeat (6) @(posedge pclk);
            check(enc_lines_filtered, 3'b101);
            $display("encoder filter test done");
        end
    endtask
    task automatic t_loop;
        begin
            motion_running <= 1'b1;
            internal_position <= 32'h1234_5678;
            cmd(`CMD_SINGLE_LOOP, `DATA_ZERO, `DATA_ZERO, 2'b10);
            check(target_r, 32'h0000_0000);
            motion_running <= 1'b0;
            cmd(`CMD_SINGLE_LOOP, `DATA_ZERO, `DATA_ZERO, 2'b01);
            rd(`OFF_TARGET);
            check(q, 32'h1234_5678);
            check(single_loop_r, 1'b1);
            $display("single loop test done");
        end
    endtask
    task automatic t_modes;
        begin
            for (int m = 0; m < 8; m++)
            begin
                cmd(`CMD_SET_MODE, m[15:0], dv[m], 2'b01);
                check(out_of(m), (m == 7) ? 16'h0001 : dv[m]);
            end
            cmd(`CMD_SET_MODE, `MODE_AFB, 16'h0005, 2'b10);
            check(feedback_src_r, 3'h3);
            cmd(`CMD_SET_MODE, 16'h0008, `DATA_ONE, 2'b10);
            fieldbus_fitted <= 1'b0;
            cmd(`CMD_SET_MODE, `MODE_LIMIT, `DATA_ZERO, 2'b10);
            check(limit_enable_r, 1'b1);
            fieldbus_fitted <= 1'b1;
            cmd(`CMD_SET_MODE, `MODE_LIMIT, `DATA_ZERO, 2'b01);
            check(limit_enable_r, 1'b0);
            $display("set mode test done");
        end
    endtask
    task automatic t_pulse;
        begin
            // prescale is 2^4 from the set mode test
            pulse_in6 <= 1'b1;
            pulse_in7 <= 1'b1;
            repeat (81) @(posedge pclk);
            pulse_in6 <= 1'b0;
            repeat (80) @(posedge pclk);
            pulse_in7 <= 1'b0;
            repeat (4) @(posedge pclk);
            check({pw_high6_r, pw_high7_r}, 32'h0005_000A);
            cmd(`CMD_SET_MODE, `MODE_PWIDTH, `DATA_ZERO, 2'b01);
            check(pw_enable_r, 1'b0);
            rd(8'h40);
            check(e, 1'b1);
            rd(`OFF_CONFIG);
            check(e, 1'b0);
            $display("pulse width and bus test done");
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    initial
    begin
        reset_dut;
        t_serial;
        t_filter;
        t_loop;
        t_modes;
        t_pulse;
        end_of_test;
    end
endmodule
`default_nettype wire
